// file: hw/udr_consts.svh
/*
 constants of the serial data port block: register offsets, field positions,
 reset values and bus answers.
 assumes inclusion by the block's module, its bus checker and its bench.
*/
`ifndef UDR_CONSTS_SVH
`define UDR_CONSTS_SVH

// register byte offsets
`define UDR_OFF_DATA 8'h00
`define UDR_OFF_RSR 8'h04
`define UDR_OFF_DIV 8'h24
`define UDR_OFF_LCR 8'h2c
`define UDR_OFF_IMASK 8'h38
`define UDR_OFF_ISTAT 8'h3c

// line control fields
`define UDR_LCR_PEN 0
`define UDR_LCR_EVEN 1
`define UDR_LCR_STICK 2
`define UDR_LCR_FIFO 3

// status fields in a receive entry and in the rx status register
`define UDR_ST_FRM 0
`define UDR_ST_PAR 1
`define UDR_ST_BRK 2
`define UDR_ST_OE 3

// interrupt event bits
`define UDR_EV_RX 0
`define UDR_EV_FRM 1
`define UDR_EV_PAR 2
`define UDR_EV_BRK 3
`define UDR_EV_OE 4

// reset values
`define UDR_DIV_RST 16'h01b2
`define UDR_LCR_RST 4'h0
`define UDR_IMASK_RST 5'h00

// axi answers
`define UDR_RESP_OKAY 2'h0
`define UDR_RESP_SLVERR 2'h2

`endif

// file: hw/udr_pkg.sv
/*
 types of the serial data port block: transmitter and receiver states.
 assumes nothing beyond a systemverilog compiler.
*/
package udr_pkg;

typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PAR,
    TX_STOP
} udr_tx_st_t;

typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP,
    RX_BRK
} udr_rx_st_t;

endpackage

// file: hw/udr_data_port.sv
/*
 serial port data path: axi4-lite slave, transmit and receive fifos, the
 bit-level transmitter and receiver, receive error flags and an interrupt.
 assumes one clock, a synchronous active-high reset, rxd from a pin
 (synchronised here) and 8 data bits with one stop bit.
*/
// Chosen here: the AXI4-Lite register port and the address map.
//////////////////////////////////////////////////////////////////////////////
// Contract
// - fifo mode: data write pushes tx fifo
// - no fifo: one tx holding entry
// - write starts start/data/parity/stop frame
// - fifo mode: rx byte+4 flags, 12 bits
// - no fifo: one rx holding entry
// - data bits 7:0 rx/tx, 31:12 reserved
// - overrun set when rx fifo full
// - overrun cleared when char fits again
// - break set after low whole frame
// - break loads one zero character only
// - after break wait high then start
// - parity flag on odd/even/stick mismatch; not set on a break here
// - framing flag when stop bit low; not set on a break here
// - fifo mode: flags travel with head char
// - status flags follow last data read
// - overrun in status set immediately
// - fifo enable bit selects fifo mode
`timescale 1ns/1ps
`include "udr_consts.svh"

module udr_data_port
    import udr_pkg::*;
#(
    parameter int TX_DEPTH = 32,
    parameter int RX_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic rxd,
    output logic txd,
    output logic irq
);

localparam int TAW = $clog2(TX_DEPTH);
localparam int RAW = $clog2(RX_DEPTH);

typedef struct packed {
    logic awv;
    logic [7:0] aw;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [3:0] lcr;
    logic [15:0] div;
    logic [4:0] imask;
    logic [4:0] istat;
    logic [TX_DEPTH-1:0][7:0] tm;
    logic [TAW-1:0] twp;
    logic [TAW-1:0] trp;
    logic [TAW:0] tcnt;
    logic [RX_DEPTH-1:0][11:0] rm;
    logic [RAW-1:0] rwp;
    logic [RAW-1:0] rrp;
    logic [RAW:0] rcnt;
    logic oe;
    logic [2:0] rsr;
    logic rx1;
    logic rx2;
    udr_tx_st_t tst;
    logic [15:0] tc;
    logic [2:0] tb;
    logic [7:0] tsh;
    logic tpar;
    logic txd;
    udr_rx_st_t rst_;
    logic [15:0] rc;
    logic [2:0] rb;
    logic [7:0] rsh;
    logic rpar;
} udr_state_t;

udr_state_t s;
udr_state_t next_s;

//////////////////////////////////////////////////////////////////////////////

function automatic logic exp_par(input logic [3:0] l, input logic [7:0] d);
    if (l[`UDR_LCR_STICK]) begin
        exp_par = ~l[`UDR_LCR_EVEN];
    end else begin
        exp_par = l[`UDR_LCR_EVEN] ? ^d : ~^d;
    end
endfunction

always_comb begin
    logic tx_full;
    logic rx_full;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [11:0] rx_word;
    logic [11:0] head;
    logic [4:0] ev;
    logic [4:0] clr;
    logic bit_end;
    logic brk;
    logic fifo_enable_bit;
    next_s = s;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_word = 12'h000;
    ev = 5'h00;
    clr = 5'h00;
    brk = 1'b0;
    bit_end = 1'b0;
    head = s.rm[s.rrp];
    fifo_enable_bit = s.lcr[`UDR_LCR_FIFO];
    tx_full = fifo_enable_bit ? (s.tcnt == (TAW+1)'(TX_DEPTH)) : (s.tcnt != '0);
    rx_full = fifo_enable_bit ? (s.rcnt == (RAW+1)'(RX_DEPTH)) : (s.rcnt != '0);
    next_s.rx1 = rxd;
    next_s.rx2 = s.rx1;

    // write channel capture
    if (awvalid && !s.awv) begin
        next_s.awv = 1'b1;
        next_s.aw = awaddr[7:0];
    end
    if (wvalid && !s.wv) begin
        next_s.wv = 1'b1;
        next_s.wd = wdata;
        next_s.ws = wstrb;
    end
    if (s.bv && bready) begin
        next_s.bv = 1'b0;
    end
    if (s.awv && s.wv && !s.bv) begin
        next_s.awv = 1'b0;
        next_s.wv = 1'b0;
        next_s.bv = 1'b1;
        next_s.br = `UDR_RESP_OKAY;
        unique case (s.aw)
            `UDR_OFF_DATA: begin
                if (s.ws[0] && !tx_full) begin
                    tx_push = 1'b1;
                end
            end
            `UDR_OFF_RSR: begin
                next_s.rsr = 3'h0;
                next_s.oe = 1'b0;
            end
            `UDR_OFF_DIV: begin
                if (s.ws[0]) begin
                    next_s.div[7:0] = s.wd[7:0];
                end
                if (s.ws[1]) begin
                    next_s.div[15:8] = s.wd[15:8];
                end
            end
            `UDR_OFF_LCR: begin
                if (s.ws[0]) begin
                    next_s.lcr = s.wd[3:0];
                end
            end
            `UDR_OFF_IMASK: begin
                if (s.ws[0]) begin
                    next_s.imask = s.wd[4:0];
                end
            end
            `UDR_OFF_ISTAT: begin
                if (s.ws[0]) begin
                    clr = s.wd[4:0];
                end
            end
            default: begin
                next_s.br = `UDR_RESP_SLVERR;
            end
        endcase
    end

    // read channel
    if (s.rv && rready) begin
        next_s.rv = 1'b0;
    end
    if (arvalid && !s.rv) begin
        next_s.rv = 1'b1;
        next_s.rr = `UDR_RESP_OKAY;
        next_s.rd = 32'h0000_0000;
        unique case (araddr[7:0])
            `UDR_OFF_DATA: begin
                if (s.rcnt != '0) begin
                    next_s.rd = {20'h00000, head};
                    rx_pop = 1'b1;
                    next_s.rsr = head[10:8];
                end
            end
            `UDR_OFF_RSR: begin
                next_s.rd = {28'h0000000, s.oe, s.rsr};
            end
            `UDR_OFF_DIV: begin
                next_s.rd = {16'h0000, s.div};
            end
            `UDR_OFF_LCR: begin
                next_s.rd = {28'h0000000, s.lcr};
            end
            `UDR_OFF_IMASK: begin
                next_s.rd = {27'h0000000, s.imask};
            end
            `UDR_OFF_ISTAT: begin
                next_s.rd = {27'h0000000, s.istat};
            end
            default: begin
                next_s.rr = `UDR_RESP_SLVERR;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // transmitter
    bit_end = (s.tc == s.div - 16'h0001) || (s.div == 16'h0000);
    next_s.tc = bit_end ? 16'h0000 : s.tc + 16'h0001;
    unique case (s.tst)
        TX_IDLE: begin
            next_s.tc = 16'h0000;
            if (s.tcnt != '0) begin
                tx_pop = 1'b1;
                next_s.tsh = s.tm[s.trp];
                next_s.tpar = exp_par(s.lcr, s.tm[s.trp]);
                next_s.txd = 1'b0;
                next_s.tst = TX_START;
            end
        end
        TX_START: begin
            if (bit_end) begin
                next_s.txd = s.tsh[0];
                next_s.tb = 3'h0;
                next_s.tst = TX_DATA;
            end
        end
        TX_DATA: begin
            if (bit_end) begin
                next_s.tsh = {1'b0, s.tsh[7:1]};
                next_s.tb = s.tb + 3'h1;
                if (s.tb == 3'h7) begin
                    next_s.txd = s.lcr[`UDR_LCR_PEN] ? s.tpar : 1'b1;
                    next_s.tst = s.lcr[`UDR_LCR_PEN] ? TX_PAR : TX_STOP;
                end else begin
                    next_s.txd = s.tsh[1];
                end
            end
        end
        TX_PAR: begin
            if (bit_end) begin
                next_s.txd = 1'b1;
                next_s.tst = TX_STOP;
            end
        end
        TX_STOP: begin
            if (bit_end) begin
                next_s.tst = TX_IDLE;
            end
        end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // receiver, reads only the second sync stage
    bit_end = (s.rc == s.div - 16'h0001) || (s.div == 16'h0000);
    next_s.rc = bit_end ? 16'h0000 : s.rc + 16'h0001;
    unique case (s.rst_)
        RX_IDLE: begin
            next_s.rc = 16'h0000;
            if (!s.rx2) begin
                next_s.rst_ = RX_START;
            end
        end
        RX_START: begin
            // mid-bit recheck rejects glitches
            if (s.rc == {1'b0, s.div[15:1]}) begin
                next_s.rc = 16'h0000;
                next_s.rb = 3'h0;
                next_s.rst_ = s.rx2 ? RX_IDLE : RX_DATA;
            end
        end
        RX_DATA: begin
            if (bit_end) begin
                next_s.rsh = {s.rx2, s.rsh[7:1]};
                next_s.rb = s.rb + 3'h1;
                if (s.rb == 3'h7) begin
                    next_s.rst_ = s.lcr[`UDR_LCR_PEN] ? RX_PAR : RX_STOP;
                end
            end
        end
        RX_PAR: begin
            if (bit_end) begin
                next_s.rpar = s.rx2;
                next_s.rst_ = RX_STOP;
            end
        end
        RX_STOP: begin
            if (bit_end) begin
                brk = !s.rx2 && (s.rsh == 8'h00) && !(s.lcr[`UDR_LCR_PEN] && s.rpar);
                rx_word[7:0] = s.rsh;
                rx_word[8+`UDR_ST_BRK] = brk;
                rx_word[8+`UDR_ST_FRM] = !s.rx2 && !brk;
                rx_word[8+`UDR_ST_PAR] = s.lcr[`UDR_LCR_PEN] && !brk && (s.rpar != exp_par(s.lcr, s.rsh));
                rx_word[8+`UDR_ST_OE] = s.oe;
                next_s.rst_ = brk ? RX_BRK : RX_IDLE;
                if (rx_full) begin
                    ev[`UDR_EV_OE] = 1'b1;
                end else begin
                    rx_push = 1'b1;
                    ev[`UDR_EV_RX] = 1'b1;
                    ev[`UDR_EV_FRM] = rx_word[8+`UDR_ST_FRM];
                    ev[`UDR_EV_PAR] = rx_word[8+`UDR_ST_PAR];
                    ev[`UDR_EV_BRK] = brk;
                end
            end
        end
        RX_BRK: begin
            next_s.rc = 16'h0000;
            if (s.rx2) begin
                next_s.rst_ = RX_IDLE;
            end
        end
        default: begin
            next_s.rst_ = RX_IDLE;
        end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // fifo storage and counts
    if (tx_push) begin
        next_s.tm[s.twp] = s.wd[7:0];
        next_s.twp = s.twp + TAW'(1);
    end
    if (tx_pop) begin
        next_s.trp = s.trp + TAW'(1);
    end
    next_s.tcnt = s.tcnt + (TAW+1)'(tx_push) - (TAW+1)'(tx_pop);
    // byte and four flags, one entry
    if (rx_push) begin
        next_s.rm[s.rwp] = rx_word;
        next_s.rwp = s.rwp + RAW'(1);
        next_s.oe = 1'b0;
    end
    if (rx_pop) begin
        next_s.rrp = s.rrp + RAW'(1);
    end
    next_s.rcnt = s.rcnt + (RAW+1)'(rx_push) - (RAW+1)'(rx_pop);
    if (ev[`UDR_EV_OE]) begin
        next_s.oe = 1'b1;
    end
    // sticky events, set beats clear
    next_s.istat = (s.istat & ~clr) | ev;
end

always_ff @(posedge clk) begin
    if (rst) begin
        s <= '0;
        s.lcr <= `UDR_LCR_RST;
        s.div <= `UDR_DIV_RST;
        s.imask <= `UDR_IMASK_RST;
        s.txd <= 1'b1;
        s.rx1 <= 1'b1;
        s.rx2 <= 1'b1;
        s.tst <= TX_IDLE;
        s.rst_ <= RX_IDLE;
    end else begin
        s <= next_s;
    end
end

// no new write is taken while its answer stands
assign awready = !s.awv && !s.bv;
assign wready = !s.wv && !s.bv;
assign bvalid = s.bv;
assign bresp = s.br;
assign arready = !s.rv;
assign rvalid = s.rv;
assign rdata = s.rd;
assign rresp = s.rr;
assign txd = s.txd;
assign irq = |(s.istat & s.imask);

endmodule

// file: verification/udr_data_port_assertions.sv
/*
 bus checker of the serial data port, bound to its top module.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "udr_consts.svh"

module udr_data_port_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wr;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd;
        arvalid && arready;
    endsequence
    ////////////////////////////////////////
    chk_write_answer: assert property (s_wr |-> ##2 bvalid)
        else $error("write answer late");
    chk_write_once: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
    chk_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
    chk_read_answer: assert property (s_rd |=> rvalid)
        else $error("read answer late");
    chk_read_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    chk_read_busy: assert property (rvalid |-> !arready)
        else $error("read taken while answering");
    chk_rsvd_zero: assert property (rvalid |-> rdata[31:12] == 20'h0)
        else $error("reserved read bits set");
    chk_err_zero: assert property (rvalid && rresp == `UDR_RESP_SLVERR |-> rdata == 32'h0)
        else $error("error read carries data");
endmodule

bind udr_data_port udr_data_port_chk u_chk (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

// file: verification/udr_serial_peer.sv
/*
 remote serial peer: sends frames on rxd, collects frames seen on txd.
 assumes the bench keeps par_en equal to the port's parity enable.
*/
`timescale 1ns/1ps

module udr_serial_peer #(
    parameter int BIT = 8
) (
    input wire logic clk,
    input wire logic par_en,
    input wire logic txd,
    output logic rxd
);
    logic [9:0] got[$];
    logic [9:0] f;
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] d, input logic pb, input logic sb);
        for (int i = 0; i < 11; i++) begin
            rxd <= (i == 0) ? 1'b0 : (i < 9) ? d[i-1] : (i == 9) ? (par_en ? pb : sb) : (par_en ? sb : 1'b1);
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    task automatic brk(input int n);
        rxd <= 1'b0;
        repeat (n * BIT) @(posedge clk);
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge clk);
    endtask
    ////////////////////////////////////////
    // stored as parity, stop, data
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < (par_en ? 10 : 9); i++) begin
            repeat (BIT) @(posedge clk);
            f[i] = txd;
        end
        got.push_back(par_en ? {f[8], f[9], f[7:0]} : {1'b0, f[8], f[7:0]});
    end
endmodule

// file: verification/uart_data_and_rx_status_tb.sv
/*
 bench of the serial data port: axi4-lite master tasks, a queue model
 of entries and a serial peer.
 assumes design, checker and peer compiled first.
*/
`timescale 1ns/1ps
`include "udr_consts.svh"

module uart_data_and_rx_status_tb;
    localparam int BIT = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, par_en = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, v;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, txd, irq, rxd, p;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] d;
    logic [3:0] lcr;
    logic [3:0] modes[5] = '{4'h8, 4'h9, 4'hb, 4'hd, 4'hf};
    int n_mismatch = 0, n_tests = 0, seed = 92144;
    int q[$];

    always #10 clk = ~clk;

    udr_data_port dut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .rxd(rxd), .txd(txd), .irq(irq));
    udr_serial_peer #(.BIT(BIT)) peer (.clk(clk), .par_en(par_en), .txd(txd), .rxd(rxd));

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [1:0] er);
        @(posedge clk);
        awaddr <= {24'h0, a};
        wdata <= dw;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rs = rresp;
        chk(nm, e, rdata);
    endtask
    task automatic pop();
        rd(`UDR_OFF_DATA, q.pop_front(), "rx entry");
    endtask
    function automatic logic pbit(input logic [3:0] l, input logic [7:0] x);
        return l[2] ? !l[1] : (l[1] ? ^x : ~^x);
    endfunction
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`UDR_OFF_LCR, 32'h0, "lcr");
        wr(`UDR_OFF_DIV, BIT, `UDR_RESP_OKAY);
        wr(8'h10, 32'h0, `UDR_RESP_SLVERR);
        rd(8'h10, 32'h0, "unmapped");
        chk("rresp", 32'(`UDR_RESP_SLVERR), 32'(rs));
        foreach (modes[i]) begin
            lcr = modes[i];
            par_en <= lcr[0];
            wr(`UDR_OFF_LCR, 32'(lcr), `UDR_RESP_OKAY);
            for (int k = 0; k < 3; k++) begin
                d = 8'($random(seed)) | 8'h01;
                p = pbit(lcr, d);
                peer.send(d, p ^ (k == 1), k != 2);
                q.push_back({22'h0, k == 1 && lcr[0], k == 2, d});
            end
            for (int k = 0; k < 3; k++) begin
                v = q[0];
                pop();
                rd(`UDR_OFF_RSR, 32'(v[10:8]), "rsr");
            end
        end
        peer.brk(13);
        q.push_back(32'h400);
        pop();
        rd(`UDR_OFF_RSR, 32'h4, "rsr brk");
        rd(`UDR_OFF_DATA, 32'h0, "empty");
        d = 8'($random(seed));
        peer.send(d, pbit(lcr, d), 1'b1);
        q.push_back(32'(d));
        pop();
        lcr = 4'h0;
        par_en <= 1'b0;
        wr(`UDR_OFF_LCR, 32'h0, `UDR_RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            d = 8'($random(seed));
            peer.send(d, 1'b0, 1'b1);
            q.push_back(k == 2 ? 32'h800 | d : 32'(d));
            if (k < 2) begin
                peer.send(8'h5a, 1'b0, 1'b1);
                rd(`UDR_OFF_RSR, 32'h8, "oe live");
            end
            if (k == 0) begin
                wr(`UDR_OFF_RSR, $random(seed), `UDR_RESP_OKAY);
                rd(`UDR_OFF_RSR, 32'h0, "rsr clr");
            end
            pop();
        end
        rd(`UDR_OFF_RSR, 32'h0, "oe gone");
        for (int m = 0; m < 2; m++) begin
            lcr = m ? 4'h0 : 4'hb;
            par_en <= lcr[0];
            wr(`UDR_OFF_LCR, 32'(lcr), `UDR_RESP_OKAY);
            for (int k = 0; k < 2; k++) begin
                v = $random(seed);
                wr(`UDR_OFF_DATA, v, `UDR_RESP_OKAY);
                q.push_back({lcr[0] & ^v[7:0], 1'b1, v[7:0]});
            end
            for (int t = 0; t < 3000 && peer.got.size() < 2; t++) @(posedge clk);
            for (int k = 0; k < 2; k++) chk("tx frame", q.pop_front(), 32'(peer.got.pop_front()));
        end
        chk("irq off", 32'h0, 32'(irq));
        wr(`UDR_OFF_IMASK, 32'h1, `UDR_RESP_OKAY);
        chk("irq on", 32'h1, 32'(irq));
        wr(`UDR_OFF_ISTAT, 32'h1f, `UDR_RESP_OKAY);
        chk("irq clr", 32'h0, 32'(irq));
        rd(`UDR_OFF_ISTAT, 32'h0, "istat");
        print_verdict();
    end
endmodule
